// >>> acs_adc_ctrl.v
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "acs_defs.vh"

// Overview of operation
// - Convert selected input to 10 bits, demand or continuous
// - Coarse four MSBs then fine six LSBs
// - Clear picks input 0; write latches address
// - Undriven select inputs read as low
// - Power-down freezes data outputs
// - Drive data only while output enable low
// - Bit 9 is MSB, bit 0 LSB
module acs_adc_ctrl #(
    parameter SAMPLE_W = 12
) (
    // Clock and reset
    input  wire                  clk_sys,
    input  wire                  reset_n,
    // Channel select pins
    input  wire                  select_clear_n,
    input  wire                  write_n,
    input  wire                  channel_addr_bit2,
    input  wire                  channel_addr_bit1,
    input  wire                  channel_addr_bit0,
    input  wire                  low_power_hold,
    input  wire                  output_enable_n,
    // Sampled analog inputs, one word per channel
    input  wire [8*SAMPLE_W-1:0] analog_samples,
    // Data pins
    output reg  [9:0]            result_out,
    output reg  [9:0]            result_oe,
    output reg                   over_range_flag,
    output reg                   power_save,
    output reg  [2:0]            channel_sel,
    output reg                   irq,
    // AXI4-Lite slave
    input  wire [4:0]            s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [4:0]            s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_WAIT = 3'b100;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg  [6:0] pinMeta_q;
    reg  [6:0] pinSync_q;
    wire       clrN = pinSync_q[6];
    wire       wrN  = pinSync_q[5];
    wire [2:0] addr = pinSync_q[4:2];
    wire       pd   = pinSync_q[1];
    wire       oeN  = pinSync_q[0];

    always @(posedge clk_sys) begin
        // Reset state low matches the pull-downs on undriven pins.
        if (!reset_n) begin
            pinMeta_q <= 7'h00;
            pinSync_q <= 7'h00;
        end else begin
            pinMeta_q <= {select_clear_n, write_n, channel_addr_bit2, channel_addr_bit1,
                          channel_addr_bit0, low_power_hold, output_enable_n};
            pinSync_q <= pinMeta_q;
        end
    end

    // ------------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------------
    reg  [1:0]  ctrl_q;
    reg  [1:0]  irqStat_q;
    reg  [1:0]  irqMask_q;
    reg  [7:0]  div_q;
    reg  [7:0]  divCnt_q;
    reg         startReq_q;
    reg  [2:0]  state_q;
    reg  [2:0]  chan_q;
    reg  [10:0] latest_q;
    reg  [9:0]  frozen_q;
    reg         frozenOvr_q;
    reg         awDone_q;
    reg         wDone_q;
    reg  [4:0]  awAddr_q;
    reg  [31:0] wData_q;
    reg  [3:0]  wStrb_q;

    wire        convDone;
    wire [9:0]  convResult;
    wire        convOvr;
    wire        tick     = (divCnt_q == 8'h00);
    wire        convGo   = (state_q == ST_IDLE) && !pd &&
                           (startReq_q || (ctrl_q[`ACS_CTRL_CONT] && tick));
    wire        wrFire   = awDone_q && wDone_q && !s_axi_bvalid;
    wire [31:0] divMin   = `ACS_MIN_DIV;
    wire [7:0]  divLimit = (divMin > 32'h000000ff) ? 8'hff : divMin[7:0];

    function [31:0] mergeStrb;
        input [31:0] oldv;
        input [31:0] newv;
        input [3:0]  strb;
        integer i;
        begin
            mergeStrb = oldv;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    mergeStrb[8*i +: 8] = newv[8*i +: 8];
                end
            end
        end
    endfunction

    wire [31:0] divMerged = mergeStrb({24'h0, div_q}, wData_q, wStrb_q);

    // ------------------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            chan_q <= 3'h0;
        end else if (!clrN) begin
            chan_q <= 3'h0;
        end else if (!wrN) begin
            chan_q <= addr;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q  <= ST_IDLE;
            divCnt_q <= `ACS_DIV_RST;
        end else begin
            // Continuous-mode sample period never shorter than the 1 MHz ceiling.
            divCnt_q <= tick ? ((div_q < divLimit) ? divLimit : div_q)
                             : divCnt_q - 8'h01;
            case (state_q)
                ST_IDLE: begin
                    if (convGo) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (convDone) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    acs_two_step #(
        .SAMPLE_W (SAMPLE_W)
    ) u_two_step (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .start     (state_q == ST_CONV),
        .sample    (analog_samples[chan_q*SAMPLE_W +: SAMPLE_W]),
        .done      (convDone),
        .result    (convResult),
        .overRange (convOvr)
    );

    // ------------------------------------------------------------------------
    // Result capture and data pins
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            latest_q        <= 11'h000;
            frozen_q        <= 10'h000;
            frozenOvr_q     <= 1'b0;
            result_out      <= 10'h000;
            result_oe       <= 10'h000;
            over_range_flag <= 1'b0;
            power_save      <= 1'b0;
            channel_sel     <= 3'h0;
        end else begin
            if (convDone) begin
                latest_q <= {convOvr, convResult};
            end
            if (!pd) begin
                frozen_q    <= convDone ? convResult : latest_q[9:0];
                frozenOvr_q <= convDone ? convOvr : latest_q[10];
            end
            // Pins hold their word while powered down.
            result_out      <= frozen_q;
            over_range_flag <= frozenOvr_q;
            result_oe       <= {10{!oeN}};
            power_save      <= pd;
            channel_sel     <= chan_q;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awDone_q      <= 1'b0;
            wDone_q       <= 1'b0;
            awAddr_q      <= 5'h00;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
            ctrl_q        <= `ACS_CTRL_RST;
            irqMask_q     <= `ACS_MASK_RST;
            div_q         <= `ACS_DIV_RST;
            startReq_q    <= 1'b0;
            irqStat_q     <= 2'h0;
            irq           <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q      <= s_axi_awaddr;
                awDone_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                wDone_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (convGo) begin
                startReq_q <= 1'b0;
            end
            if (wrFire) begin
                awDone_q     <= 1'b0;
                wDone_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (awAddr_q & 5'h1c)
                    `ACS_REG_CTRL: begin
                        ctrl_q[`ACS_CTRL_CONT] <= wStrb_q[0] ? wData_q[`ACS_CTRL_CONT]
                                                             : ctrl_q[`ACS_CTRL_CONT];
                        if (wStrb_q[0] && wData_q[`ACS_CTRL_START]) begin
                            startReq_q <= 1'b1;
                        end
                    end
                    `ACS_REG_IRQ_MASK: irqMask_q <= wStrb_q[0] ? wData_q[1:0] : irqMask_q;
                    `ACS_REG_DIVIDER:  div_q <= divMerged[7:0];
                    `ACS_REG_SELECT, `ACS_REG_RESULT, `ACS_REG_STATUS,
                    `ACS_REG_IRQ_STAT: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            // Status bits: hardware set wins over write-one-to-clear.
            irqStat_q[`ACS_IRQ_DONE] <= (convDone) ? 1'b1 :
                ((wrFire && (awAddr_q & 5'h1c) == `ACS_REG_IRQ_STAT && wStrb_q[0] &&
                  wData_q[`ACS_IRQ_DONE]) ? 1'b0 : irqStat_q[`ACS_IRQ_DONE]);
            irqStat_q[`ACS_IRQ_OVR] <= (convDone && convOvr) ? 1'b1 :
                ((wrFire && (awAddr_q & 5'h1c) == `ACS_REG_IRQ_STAT && wStrb_q[0] &&
                  wData_q[`ACS_IRQ_OVR]) ? 1'b0 : irqStat_q[`ACS_IRQ_OVR]);
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'h0;
                case (s_axi_araddr & 5'h1c)
                    `ACS_REG_CTRL:     s_axi_rdata <= {30'h0, ctrl_q[1], startReq_q};
                    `ACS_REG_SELECT:   s_axi_rdata <= {29'h0, chan_q};
                    `ACS_REG_RESULT:   s_axi_rdata <= {21'h0, latest_q};
                    `ACS_REG_STATUS:   s_axi_rdata <= {28'h0, pd, !oeN,
                                                      state_q != ST_IDLE, startReq_q};
                    `ACS_REG_IRQ_STAT: s_axi_rdata <= {30'h0, irqStat_q};
                    `ACS_REG_IRQ_MASK: s_axi_rdata <= {30'h0, irqMask_q};
                    `ACS_REG_DIVIDER:  s_axi_rdata <= {24'h0, div_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// >>> acs_defs.vh
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACS_REG_CTRL      5'h00
`define ACS_REG_SELECT    5'h04
`define ACS_REG_RESULT    5'h08
`define ACS_REG_STATUS    5'h0c
`define ACS_REG_IRQ_STAT  5'h10
`define ACS_REG_IRQ_MASK  5'h14
`define ACS_REG_DIVIDER   5'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACS_CTRL_START    0
`define ACS_CTRL_CONT     1
`define ACS_IRQ_DONE      0
`define ACS_IRQ_OVR       1
`define ACS_RESULT_OVR    10

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define ACS_CTRL_RST      2'h0
`define ACS_MASK_RST      2'h0
`define ACS_DIV_RST       8'h18
`define ACS_CLK_HZ        25000000
`define ACS_MAX_RATE_HZ   1000000
`define ACS_MIN_DIV       ((`ACS_CLK_HZ + `ACS_MAX_RATE_HZ - 1) / `ACS_MAX_RATE_HZ - 1)

`endif

// >>> acs_two_step.v
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Two-step quantiser: coarse 4 bits, then fine 6 bits from the residue.
// ----------------------------------------------------------------------------
module acs_two_step #(
    parameter SAMPLE_W = 12
) (
    // Clock and reset
    input  wire                clk_sys,
    input  wire                reset_n,
    // Request
    input  wire                start,
    input  wire [SAMPLE_W-1:0] sample,
    // Answer
    output reg                 done,
    output reg  [9:0]          result,
    output reg                 overRange
);
    reg        busy_q;
    reg  [3:0] coarse_q;
    reg  [5:0] residue_q;
    reg        ovr_q;

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            busy_q    <= 1'b0;
            coarse_q  <= 4'h0;
            residue_q <= 6'h00;
            ovr_q     <= 1'b0;
            done      <= 1'b0;
            result    <= 10'h000;
            overRange <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy_q) begin
                // Above full scale the code saturates and the flag rises.
                ovr_q <= |sample[SAMPLE_W-1:10];
                if (|sample[SAMPLE_W-1:10]) begin
                    coarse_q  <= 4'hf;
                    residue_q <= 6'h3f;
                end else begin
                    coarse_q  <= sample[9:6];
                    residue_q <= sample[5:0];
                end
                busy_q <= 1'b1;
            end else if (busy_q) begin
                result    <= {coarse_q, residue_q};
                overRange <= ovr_q;
                done      <= 1'b1;
                busy_q    <= 1'b0;
            end
        end
    end
endmodule

// >>> acs_adc_ctrl_assertions.sv
`timescale 1ns/1ns

module acs_adc_ctrl_assertions (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Pins
    input wire logic        select_clear_n,
    input wire logic        write_n,
    input wire logic        channel_addr_bit2,
    input wire logic        channel_addr_bit1,
    input wire logic        channel_addr_bit0,
    input wire logic        low_power_hold,
    input wire logic        output_enable_n,
    input wire logic [9:0]  result_out,
    input wire logic [9:0]  result_oe,
    input wire logic        over_range_flag,
    input wire logic        power_save,
    input wire logic [2:0]  channel_sel,
    // Bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_clear_first: assert property (
        (!select_clear_n)[*5] |-> channel_sel == 3'h0) else $error("clear not honoured");
    a_write_addr: assert property (
        (select_clear_n && !write_n && $stable({channel_addr_bit2, channel_addr_bit1,
        channel_addr_bit0}))[*5]
        |-> channel_sel == {channel_addr_bit2, channel_addr_bit1, channel_addr_bit0})
        else $error("address not latched");
    a_hold_sel: assert property (
        (select_clear_n && write_n)[*5] |-> $stable(channel_sel)) else $error("selection moved");
    a_oe_off: assert property (
        output_enable_n[*4] |-> result_oe == 10'h000) else $error("driving while disabled");
    a_oe_on: assert property (
        (!output_enable_n)[*4] |-> result_oe == 10'h3ff) else $error("not driving");
    a_sleep_freeze: assert property (
        low_power_hold[*5] |-> $stable(result_out) && power_save) else $error("word moved");
    a_over_word: assert property (
        over_range_flag |-> result_out == 10'h3ff) else $error("overflow word wrong");
    a_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule

bind acs_adc_ctrl acs_adc_ctrl_assertions u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .select_clear_n(select_clear_n),
    .write_n(write_n), .channel_addr_bit2(channel_addr_bit2),
    .channel_addr_bit1(channel_addr_bit1), .channel_addr_bit0(channel_addr_bit0),
    .low_power_hold(low_power_hold), .output_enable_n(output_enable_n),
    .result_out(result_out), .result_oe(result_oe), .over_range_flag(over_range_flag),
    .power_save(power_save), .channel_sel(channel_sel), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// >>> acs_host_model.sv
`timescale 1ns/1ns

module acs_host_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Requests
    input  wire logic [2:0] reqAddr,
    input  wire logic       reqWrite,
    input  wire logic       reqClear,
    input  wire logic       reqFloat,
    input  wire logic       reqSleep,
    input  wire logic       reqRead,
    // Pins
    output logic            clearN,
    output logic            writeN,
    output logic      [2:0] addrPins,
    output logic            sleepPin,
    output logic            oeN,
    input  wire logic [9:0] resultOut,
    input  wire logic [9:0] resultOe,
    output logic      [9:0] busWord
);
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            clearN   <= 1'b0;
            writeN   <= 1'b1;
            addrPins <= 3'h0;
            sleepPin <= 1'b0;
            oeN      <= 1'b1;
            busWord  <= 10'h000;
        end else begin
            // Undriven select pins fall to their pull-down level.
            clearN   <= reqFloat ? 1'b0 : !reqClear;
            writeN   <= reqFloat ? 1'b0 : !reqWrite;
            addrPins <= reqFloat ? 3'h0 : reqAddr;
            sleepPin <= reqSleep;
            oeN      <= !reqRead;
            // Released data lines show a pattern that changes every cycle.
            busWord  <= (resultOe & resultOut) | (~resultOe & ~busWord);
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/1ns
`include "acs_defs.vh"

module testbench;
    // ----
    // Signals
    // ----
    typedef struct {logic [11:0] sample; logic [9:0] word; logic ovr;} acs_row_t;
    logic        clk_sys, reset_n, hostWrite, hostClear, hostFloat, hostSleep, hostRead;
    logic [2:0]  hostAddr, addrPins, channelSel;
    logic        clearN, writeN, sleepPin, oeN, overFlag, powerSave, irq;
    logic [9:0]  resultOut, resultOe, busWord;
    logic [95:0] samples;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic        arready, rvalid;
    acs_row_t    rows [8];
    int          mismatches, compares, i;

    acs_host_model u_host (.clk_sys(clk_sys), .reset_n(reset_n), .reqAddr(hostAddr),
        .reqWrite(hostWrite), .reqClear(hostClear), .reqFloat(hostFloat),
        .reqSleep(hostSleep), .reqRead(hostRead), .clearN(clearN), .writeN(writeN),
        .addrPins(addrPins), .sleepPin(sleepPin), .oeN(oeN), .resultOut(resultOut),
        .resultOe(resultOe), .busWord(busWord));

    acs_adc_ctrl #(.SAMPLE_W(12)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .select_clear_n(clearN), .write_n(writeN), .channel_addr_bit2(addrPins[2]),
        .channel_addr_bit1(addrPins[1]), .channel_addr_bit0(addrPins[0]),
        .low_power_hold(sleepPin), .output_enable_n(oeN), .analog_samples(samples),
        .result_out(resultOut), .result_oe(resultOe), .over_range_flag(overFlag),
        .power_save(powerSave), .channel_sel(channelSel), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ----
    // Tasks
    // ----
    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        compares++;
        if (got !== expv) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, expv, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic axiWrite(input logic [4:0] addr, input logic [31:0] data);
        logic aw, w, b;
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bready & bvalid;
            @(posedge clk_sys);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
    endtask

    task automatic axiRead(input logic [4:0] addr);
        logic ar, r;
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ar = arvalid & arready;
            r = rready & rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge clk_sys);
            if (ar) arvalid <= 1'b0;
        end while (!r);
    endtask

    task automatic waitIrq(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (irq !== lvl && n < 200);
        check("irq", lvl, irq);
        @(posedge clk_sys);
    endtask

    task automatic selectChannel(input logic [2:0] ch);
        hostAddr <= ch;
        hostWrite <= 1'b1;
        step(8);
        hostWrite <= 1'b0;
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        step(20000);
        mismatches++;
        finish_test;
    end

    // ----
    // Sequence
    // ----
    initial begin
        rows[0] = '{12'h000, 10'h000, 1'b0};
        rows[1] = '{12'h3ff, 10'h3ff, 1'b0};
        rows[2] = '{12'h200, 10'h200, 1'b0};
        rows[3] = '{12'h155, 10'h155, 1'b0};
        rows[4] = '{12'h2aa, 10'h2aa, 1'b0};
        rows[5] = '{12'h001, 10'h001, 1'b0};
        rows[6] = '{12'h400, 10'h3ff, 1'b1};
        rows[7] = '{12'hfff, 10'h3ff, 1'b1};
        for (i = 0; i < 8; i++) samples[i*12 +: 12] = rows[i].sample;
        {reset_n, hostWrite, hostClear, hostFloat, hostSleep, hostAddr} = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = 15'h0000;
        wdata = 32'h0;
        hostRead = 1'b1;
        step(20);
        reset_n <= 1'b1;
        step(2);
        axiRead(`ACS_REG_DIVIDER);
        check("divider reset", 32'h18, rd);
        axiRead(`ACS_REG_IRQ_MASK);
        check("mask reset", 32'h0, rd);
        axiRead(5'h1c);
        check("unmapped response", 32'h2, {30'h0, rsp});
        check("unmapped data", 32'h0, rd);
        $display("reset and map test done");
        axiWrite(`ACS_REG_IRQ_MASK, 32'h3);
        check("write response", 32'h0, {30'h0, bresp});
        for (i = 0; i < 8; i++) begin
            selectChannel(i[2:0]);
            axiWrite(`ACS_REG_CTRL, 32'h1);
            waitIrq(1'b1);
            axiRead(`ACS_REG_RESULT);
            check("result register", {21'h0, rows[i].ovr, rows[i].word}, rd);
            step(8);
            @(negedge clk_sys);
            check("selected channel", i, channelSel);
            check("data lines", rows[i].word, busWord);
            check("overflow pin", rows[i].ovr, overFlag);
            @(posedge clk_sys);
            axiWrite(`ACS_REG_IRQ_STAT, 32'h3);
            $display("row %0d done", i);
        end
        hostAddr <= 3'h2;
        step(8);
        @(negedge clk_sys);
        check("held channel", 32'h7, channelSel);
        @(posedge clk_sys);
        hostClear <= 1'b1;
        step(8);
        @(negedge clk_sys);
        check("cleared channel", 32'h0, channelSel);
        @(posedge clk_sys);
        hostClear <= 1'b0;
        selectChannel(3'h5);
        hostFloat <= 1'b1;
        step(8);
        @(negedge clk_sys);
        check("floating pins", 32'h0, channelSel);
        @(posedge clk_sys);
        hostFloat <= 1'b0;
        $display("select pin test done");
        axiWrite(`ACS_REG_IRQ_MASK, 32'h0);
        axiWrite(`ACS_REG_CTRL, 32'h1);
        step(40);
        @(negedge clk_sys);
        check("masked irq", 32'h0, irq);
        @(posedge clk_sys);
        axiWrite(`ACS_REG_IRQ_MASK, 32'h3);
        waitIrq(1'b1);
        axiWrite(`ACS_REG_IRQ_STAT, 32'h3);
        waitIrq(1'b0);
        axiWrite(`ACS_REG_CTRL, 32'h2);
        waitIrq(1'b1);
        axiWrite(`ACS_REG_CTRL, 32'h0);
        $display("interrupt test done");
        selectChannel(3'h1);
        hostSleep <= 1'b1;
        step(8);
        axiWrite(`ACS_REG_CTRL, 32'h1);
        step(40);
        @(negedge clk_sys);
        check("power save", 32'h1, powerSave);
        check("frozen word", 32'h0, busWord);
        @(posedge clk_sys);
        hostSleep <= 1'b0;
        hostRead <= 1'b0;
        step(8);
        @(negedge clk_sys);
        check("output enables", 32'h0, resultOe);
        $display("power and enable test done");
        finish_test;
    end
endmodule
